// [common/timer16_pkg.sv]
// package: register map, field layout and types of the 16-bit timer
package timer16_pkg;
   localparam int unsigned CNT_W = 16;
   // register byte offsets
   localparam logic [7:0] OFF_CONTROL_A = 8'h00;
   localparam logic [7:0] OFF_CONTROL_B = 8'h04;
   localparam logic [7:0] OFF_CONTROL_E = 8'h08;
   localparam logic [7:0] OFF_CONTROL_F = 8'h0c;
   localparam logic [7:0] OFF_EVENT_CONTROL = 8'h10;
   localparam logic [7:0] OFF_COUNT = 8'h14;
   localparam logic [7:0] OFF_PERIOD = 8'h18;
   localparam logic [7:0] OFF_PERIOD_SHADOW = 8'h1c;
   localparam logic [7:0] OFF_COMPARE0 = 8'h20;
   localparam logic [7:0] OFF_COMPARE_SHADOW0 = 8'h30;
   localparam logic [7:0] OFF_MATCH_FLAGS = 8'h40;
   // field positions
   localparam int unsigned A_ENABLE_BIT = 0;
   localparam int unsigned A_PRESCALE_LSB = 1;
   localparam int unsigned B_WAVE_LSB = 0;
   localparam int unsigned B_CHAN_EN_LSB = 4;
   localparam int unsigned E_HEADING_BIT = 0;
   localparam int unsigned E_LOCK_BIT = 1;
   localparam int unsigned F_PER_VALID_BIT = 0;
   localparam int unsigned F_CMP_VALID_LSB = 1;
   localparam int unsigned EV_COUNT_EN_BIT = 0;
   // reset values and the all-ones count limit
   localparam logic [15:0] PERIOD_RESET = 16'hffff;
   localparam logic [15:0] COUNT_FLOOR = 16'h0000;
   localparam logic [15:0] ALL_ONES = 16'hffff;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;

   typedef enum logic [2:0] {
      WAVE_NORMAL = 3'b000,
      WAVE_FREQ = 3'b001
   } wave_shape_t;

   typedef struct packed {
      logic enable;
      logic [2:0] prescale_select;
      wave_shape_t wave_shape_select;
      logic [2:0] channel_output_enable;
      logic count_heading;
      logic lock_buffer_commit;
      logic count_on_event_enable;
   } timer_ctrl_t;
endpackage : timer16_pkg

// [rtl/compare_channel.sv]
// compare_channel: active/shadow compare pair, match flag, wave output
`timescale 1ns/1ps
module compare_channel (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // software access
   input wire logic wr_active,
   input wire logic wr_shadow,
   input wire logic [15:0] wdata,
   input wire logic clr_flag,
   // timing
   input wire logic tick,
   input wire logic commit,
   input wire logic [15:0] count,
   input wire logic freq_mode,
   // state
   output logic [15:0] compare_value,
   output logic [15:0] compare_shadow,
   output logic shadow_valid,
   output logic match_flag,
   output logic wave
);
   logic [15:0] cmp_d, shd_d;
   logic valid_d, flag_d, wave_d, pend_q, pend_d;

   always_comb begin
      cmp_d = compare_value;
      shd_d = compare_shadow;
      valid_d = shadow_valid;
      flag_d = match_flag;
      wave_d = wave;
      pend_d = pend_q;
      if (commit && shadow_valid) begin
         cmp_d = compare_shadow;
         valid_d = 1'b0;
      end
      if (commit) begin
         valid_d = 1'b0;
      end
      if (wr_shadow) begin
         shd_d = wdata;
         valid_d = 1'b1;
      end
      if (wr_active) begin
         cmp_d = wdata;
      end
      if (clr_flag) begin
         flag_d = 1'b0;
      end
      // match is acted on at the next tick, so it sees a stable count
      if (tick) begin
         pend_d = (count == compare_value);
         if (pend_q) begin
            flag_d = 1'b1;
            if (freq_mode) begin
               wave_d = ~wave;
            end
         end
      end
      if (!freq_mode) begin
         wave_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         compare_value <= 16'h0000;
         compare_shadow <= 16'h0000;
         shadow_valid <= 1'b0;
         match_flag <= 1'b0;
         wave <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         compare_value <= cmp_d;
         compare_shadow <= shd_d;
         shadow_valid <= valid_d;
         match_flag <= flag_d;
         wave <= wave_d;
         pend_q <= pend_d;
      end
   end
endmodule : compare_channel

// [rtl/prescaler.sv]
// prescaler: turns clk into a one-cycle tick at the selected ratio
`timescale 1ns/1ps
module prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic [2:0] prescale_select,
   // tick out
   output logic tick
);
   logic [9:0] div_q, div_d;
   logic [9:0] limit;
   logic tick_d;

   // ratio 1,2,4,8,16,64,256,1024
   always_comb begin
      unique case (prescale_select)
         3'h0: limit = 10'h000;
         3'h1: limit = 10'h001;
         3'h2: limit = 10'h003;
         3'h3: limit = 10'h007;
         3'h4: limit = 10'h00f;
         3'h5: limit = 10'h03f;
         3'h6: limit = 10'h0ff;
         3'h7: limit = 10'h3ff;
      endcase
      div_d = div_q;
      tick_d = 1'b0;
      if (!run) begin
         div_d = 10'h000;
      end else if (div_q >= limit) begin
         div_d = 10'h000;
         tick_d = 1'b1;
      end else begin
         div_d = div_q + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         div_q <= 10'h000;
         tick <= 1'b0;
      end else begin
         div_q <= div_d;
         tick <= tick_d;
      end
   end
endmodule : prescaler

// [rtl/timer16_buffered_compare.sv]
// timer16_buffered_compare: apb timer core with buffered period/compare
`timescale 1ns/1ps
module timer16_buffered_compare (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event input pin
   input wire logic event_in,
   // waveform outputs
   output logic [2:0] wave_output_pin,
   output logic [2:0] wave_output_oe,
   // floor / ceiling events
   output logic floor_event,
   output logic ceiling_event
);
   timer16_pkg::timer_ctrl_t ctrl_q, ctrl_d;
   logic [15:0] count_q, count_d;
   logic [15:0] period_q, period_d, pshadow_q, pshadow_d;
   logic pvalid_q, pvalid_d;
   logic ovf_flag_q, ovf_flag_d;
   logic ev_meta_q, ev_sync_q, ev_prev_q;
   logic ev_pulse, pre_tick, tick;
   logic [15:0] ceiling;
   logic at_floor, at_ceiling, at_max, commit, freq_mode;
   logic floor_pend_q, floor_pend_d, ceil_pend_q, ceil_pend_d;
   logic floor_ev_d, ceil_ev_d;
   logic [31:0] rdata_d;
   logic ready_d, err_d;
   logic [2:0] wave_pin_d, wave_oe_d;
   logic setup, wr, wr_count;
   logic [2:0] wr_cmp, wr_shd;
   logic [15:0] cmp [3];
   logic [15:0] shd [3];
   logic [2:0] cvalid, cflag, cwave;
   logic clr_cflag;

   // event pin is asynchronous: two flops before any logic
   always_ff @(posedge clk) begin
      if (reset) begin
         ev_meta_q <= 1'b0;
         ev_sync_q <= 1'b0;
         ev_prev_q <= 1'b0;
      end else begin
         ev_meta_q <= event_in;
         ev_sync_q <= ev_meta_q;
         ev_prev_q <= ev_sync_q;
      end
   end
   assign ev_pulse = ev_sync_q & ~ev_prev_q;

   prescaler u_prescaler (
      .clk(clk),
      .reset(reset),
      .run(ctrl_q.enable),
      .prescale_select(ctrl_q.prescale_select),
      .tick(pre_tick)
   );

   // event counting replaces clock ticks
   assign tick = ctrl_q.enable &
      (ctrl_q.count_on_event_enable ? ev_pulse : pre_tick);

   // zero-latency apb: ready in the access cycle
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;
   assign wr_count = wr && paddr == timer16_pkg::OFF_COUNT;
   assign clr_cflag = wr && paddr == timer16_pkg::OFF_MATCH_FLAGS;
   assign freq_mode = ctrl_q.wave_shape_select == timer16_pkg::WAVE_FREQ;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_chan
         assign wr_cmp[gi] = wr && paddr ==
            timer16_pkg::OFF_COMPARE0 + 8'(4 * gi);
         assign wr_shd[gi] = wr && paddr ==
            timer16_pkg::OFF_COMPARE_SHADOW0 + 8'(4 * gi);
         compare_channel u_chan (
            .clk(clk),
            .reset(reset),
            .wr_active(wr_cmp[gi]),
            .wr_shadow(wr_shd[gi]),
            .wdata(pwdata[15:0]),
            .clr_flag(clr_cflag & pwdata[gi]),
            .tick(tick),
            .commit(commit),
            .count(count_q),
            .freq_mode(freq_mode),
            .compare_value(cmp[gi]),
            .compare_shadow(shd[gi]),
            .shadow_valid(cvalid[gi]),
            .match_flag(cflag[gi]),
            .wave(cwave[gi])
         );
      end
   endgenerate

   // floor and ceiling detection
   assign ceiling = freq_mode ? cmp[0] : period_q;
   assign at_floor = count_q == timer16_pkg::COUNT_FLOOR;
   assign at_max = count_q == timer16_pkg::ALL_ONES;
   assign at_ceiling = count_q == ceiling;
   // commit at ceiling counting up, at floor counting down
   assign commit = tick & ~ctrl_q.lock_buffer_commit &
      (ctrl_q.count_heading ? at_floor : at_ceiling);

   // counter
   always_comb begin
      count_d = count_q;
      if (tick) begin
         if (!ctrl_q.count_heading) begin
            // past a lowered ceiling the counter runs on to all-ones
            count_d = (at_ceiling || at_max) ? 16'h0000 :
               count_q + 16'h0001;
         end else begin
            count_d = at_floor ? period_q : count_q - 16'h0001;
         end
      end
      if (wr_count) begin
         count_d = pwdata[15:0];
      end
   end

   // period, shadow and valid flag
   always_comb begin
      period_d = period_q;
      pshadow_d = pshadow_q;
      pvalid_d = pvalid_q;
      if (commit) begin
         if (pvalid_q) begin
            period_d = pshadow_q;
         end
         pvalid_d = 1'b0;
      end
      if (wr && paddr == timer16_pkg::OFF_PERIOD_SHADOW) begin
         pshadow_d = pwdata[15:0];
         pvalid_d = 1'b1;
      end
      if (wr && paddr == timer16_pkg::OFF_PERIOD) begin
         period_d = pwdata[15:0];
      end
   end

   // control registers
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr) begin
         unique case (paddr)
            timer16_pkg::OFF_CONTROL_A: begin
               ctrl_d.enable = pwdata[timer16_pkg::A_ENABLE_BIT];
               ctrl_d.prescale_select =
                  pwdata[timer16_pkg::A_PRESCALE_LSB +: 3];
            end
            timer16_pkg::OFF_CONTROL_B: begin
               ctrl_d.wave_shape_select = timer16_pkg::wave_shape_t'(
                  pwdata[timer16_pkg::B_WAVE_LSB +: 3]);
               ctrl_d.channel_output_enable =
                  pwdata[timer16_pkg::B_CHAN_EN_LSB +: 3];
            end
            timer16_pkg::OFF_CONTROL_E: begin
               ctrl_d.count_heading =
                  pwdata[timer16_pkg::E_HEADING_BIT];
               ctrl_d.lock_buffer_commit =
                  pwdata[timer16_pkg::E_LOCK_BIT];
            end
            timer16_pkg::OFF_EVENT_CONTROL: begin
               ctrl_d.count_on_event_enable =
                  pwdata[timer16_pkg::EV_COUNT_EN_BIT];
            end
            default: ;
         endcase
      end
   end

   // floor/ceiling effects shown at the next tick; overflow sticky flag
   always_comb begin
      floor_pend_d = floor_pend_q;
      ceil_pend_d = ceil_pend_q;
      floor_ev_d = 1'b0;
      ceil_ev_d = 1'b0;
      ovf_flag_d = ovf_flag_q;
      if (clr_cflag && pwdata[3]) begin
         ovf_flag_d = 1'b0;
      end
      if (tick) begin
         floor_pend_d = at_floor;
         ceil_pend_d = at_ceiling;
         floor_ev_d = floor_pend_q;
         ceil_ev_d = ceil_pend_q;
         if (floor_pend_q || ceil_pend_q) begin
            ovf_flag_d = 1'b1;
         end
      end
   end

   // pins: only frequency mode plus channel enable drives them
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         wave_oe_d[i] = freq_mode & ctrl_q.channel_output_enable[i];
         wave_pin_d[i] = wave_oe_d[i] & cwave[i];
      end
   end

   // apb read mux, unmapped reads give zero with pslverr
   always_comb begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      ready_d = setup;
      unique case (paddr)
         timer16_pkg::OFF_CONTROL_A: rdata_d = 32'({ctrl_q.prescale_select,
            ctrl_q.enable});
         timer16_pkg::OFF_CONTROL_B: rdata_d = 32'({
            ctrl_q.channel_output_enable, 1'b0, ctrl_q.wave_shape_select});
         timer16_pkg::OFF_CONTROL_E: rdata_d = 32'({
            ctrl_q.lock_buffer_commit, ctrl_q.count_heading});
         timer16_pkg::OFF_CONTROL_F: rdata_d = 32'({cvalid, pvalid_q});
         timer16_pkg::OFF_EVENT_CONTROL:
            rdata_d = 32'(ctrl_q.count_on_event_enable);
         timer16_pkg::OFF_COUNT: rdata_d = 32'(count_q);
         timer16_pkg::OFF_PERIOD: rdata_d = 32'(period_q);
         timer16_pkg::OFF_PERIOD_SHADOW: rdata_d = 32'(pshadow_q);
         8'h20: rdata_d = 32'(cmp[0]);
         8'h24: rdata_d = 32'(cmp[1]);
         8'h28: rdata_d = 32'(cmp[2]);
         8'h30: rdata_d = 32'(shd[0]);
         8'h34: rdata_d = 32'(shd[1]);
         8'h38: rdata_d = 32'(shd[2]);
         timer16_pkg::OFF_MATCH_FLAGS: rdata_d = 32'({ovf_flag_q, cflag});
         default: err_d = setup;
      endcase
      if (!setup) begin
         rdata_d = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_q <= '{enable: 1'b0,
            prescale_select: timer16_pkg::PRESCALE_RESET,
            wave_shape_select: timer16_pkg::WAVE_NORMAL,
            channel_output_enable: 3'h0, count_heading: 1'b0,
            lock_buffer_commit: 1'b0, count_on_event_enable: 1'b0};
         count_q <= timer16_pkg::COUNT_FLOOR;
         period_q <= timer16_pkg::PERIOD_RESET;
         pshadow_q <= 16'h0000;
         pvalid_q <= 1'b0;
         ovf_flag_q <= 1'b0;
         floor_pend_q <= 1'b0;
         ceil_pend_q <= 1'b0;
         floor_event <= 1'b0;
         ceiling_event <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         wave_output_pin <= 3'h0;
         wave_output_oe <= 3'h0;
      end else begin
         ctrl_q <= ctrl_d;
         count_q <= count_d;
         period_q <= period_d;
         pshadow_q <= pshadow_d;
         pvalid_q <= pvalid_d;
         ovf_flag_q <= ovf_flag_d;
         floor_pend_q <= floor_pend_d;
         ceil_pend_q <= ceil_pend_d;
         floor_event <= floor_ev_d;
         ceiling_event <= ceil_ev_d;
         prdata <= rdata_d;
         pready <= ready_d;
         pslverr <= err_d;
         wave_output_pin <= wave_pin_d;
         wave_output_oe <= wave_oe_d;
      end
   end
endmodule : timer16_buffered_compare

// [tb/timer16_asserts.sv]
// checker: bus handshake and pin override relations of the timer
`timescale 1ns/1ps
module timer16_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // waveform outputs
   input wire logic [2:0] wave_output_pin,
   input wire logic [2:0] wave_output_oe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   logic wr_acc;
   logic mapped;
   assign wr_acc = psel && penable && pwrite && pready;
   // word offsets that carry a register; 0x2c and 0x3c are holes
   assign mapped = (paddr[1:0] == 2'b00) && ((paddr <= 8'h28) ||
      (paddr >= 8'h30 && paddr <= 8'h38) || paddr == 8'h40);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable && pready;
   endsequence
   chk_ready_slot: assert property (setup_s |=> access_s)
      else $error("no ready in the access cycle");
   chk_ready_once: assert property (access_s |=> !pready)
      else $error("ready held past one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   chk_err_rdata: assert property (
      pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");
   chk_unmapped_err: assert property (
      (access_s and !mapped) |-> pslverr)
      else $error("hole address not refused");
   chk_mapped_ok: assert property (
      (access_s and mapped) |-> !pslverr)
      else $error("register address refused");
   chk_pin_quiet: assert property (
      (wave_output_pin & ~wave_output_oe) == 3'h0)
      else $error("wave level on an undriven channel");
   // enables follow control writes only, never the counter
   chk_oe_by_write: assert property ($changed(wave_output_oe) |->
      $past(wr_acc) || $past(wr_acc, 2))
      else $error("output enable moved without a write");
endmodule : timer16_asserts

bind timer16_buffered_compare timer16_asserts u_chk (.clk, .reset, .psel,
   .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .wave_output_pin,
   .wave_output_oe);

// [tb/timer16_buffered_compare_bench.sv]
// bench: register-level scenarios for the buffered timer
`timescale 1ns/1ps
module timer16_buffered_compare_bench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic event_in = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, floor_event, ceiling_event;
   logic [2:0] wave_output_pin, wave_output_oe, pad;
   int error_cnt = 0;
   int n_checks = 0;

   always #5 clk = ~clk;

   timer16_buffered_compare uut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .event_in(event_in), .wave_output_pin(wave_output_pin),
      .wave_output_oe(wave_output_oe), .floor_event(floor_event),
      .ceiling_event(ceiling_event));
   // port latch high so an undriven pad is told apart from a low wave
   wave_pins u_pins (.wave(wave_output_pin), .oe(wave_output_oe),
      .port_out(3'h7), .pad(pad));

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim

   task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   task automatic timed_out(input string what);
      cmp(what, 32'h1, 32'h0);
      end_sim();
   endtask : timed_out

   // entered just after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) timed_out("apb ready");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp($sformatf("reg %h", a), exp, rd);
   endtask : rdc

   task automatic wait_ev(input logic fl, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((fl ? floor_event : ceiling_event) !== 1'b1 && n < 3000);
      if (n >= 3000) timed_out("event wait");
   endtask : wait_ev

   // cycles between two successive floor or ceiling pulses
   task automatic gap(input logic fl, input int exp);
      int n;
      // skip two pulses: gaps right after a setting change are uneven
      repeat (2) wait_ev(fl, n);
      wait_ev(fl, n);
      cmp("event gap", exp, n);
   endtask : gap

   task automatic toggles(input int exp);
      int t;
      logic p;
      t = 0;
      // tick to pin takes a few flops; let the old rate drain first
      repeat (4) @(posedge clk);
      p = pad[0];
      repeat (24) begin
         @(posedge clk);
         if (pad[0] !== p) t++;
         p = pad[0];
      end
      cmp("pad toggles", exp, t);
   endtask : toggles

   task automatic t_reset;
      rdc(timer16_pkg::OFF_PERIOD, 32'h0000ffff);
      rdc(timer16_pkg::OFF_COUNT, 32'h0);
      rdc(timer16_pkg::OFF_CONTROL_F, 32'h0);
      rdc(8'h44, 32'h0);
      cmp("hole error", 32'h1, {31'h0, er});
      $display("test reset done");
   endtask : t_reset

   task automatic t_up;
      wr(timer16_pkg::OFF_PERIOD, 32'h4);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h1);
      gap(1'b0, 5);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h3);
      gap(1'b0, 10);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h1);
      $display("test up done");
   endtask : t_up

   task automatic t_shadow;
      wr(timer16_pkg::OFF_CONTROL_E, 32'h2);
      wr(timer16_pkg::OFF_PERIOD_SHADOW, 32'h7);
      rdc(timer16_pkg::OFF_CONTROL_F, 32'h1);
      gap(1'b0, 5);
      wr(timer16_pkg::OFF_CONTROL_E, 32'h0);
      gap(1'b0, 8);
      rdc(timer16_pkg::OFF_PERIOD, 32'h7);
      rdc(timer16_pkg::OFF_CONTROL_F, 32'h0);
      wr(timer16_pkg::OFF_CONTROL_E, 32'h1);
      gap(1'b1, 8);
      wr(timer16_pkg::OFF_CONTROL_E, 32'h0);
      $display("test shadow done");
   endtask : t_shadow

   task automatic t_cmp;
      wr(timer16_pkg::OFF_CONTROL_E, 32'h2);
      wr(timer16_pkg::OFF_COMPARE0 + 8'h04, 32'h5);
      rdc(timer16_pkg::OFF_COMPARE0 + 8'h04, 32'h5);
      wr(timer16_pkg::OFF_COMPARE_SHADOW0 + 8'h04, 32'h6);
      rdc(timer16_pkg::OFF_CONTROL_F, 32'h4);
      wr(timer16_pkg::OFF_CONTROL_E, 32'h0);
      gap(1'b0, 8);
      rdc(timer16_pkg::OFF_COMPARE0 + 8'h04, 32'h6);
      rdc(timer16_pkg::OFF_CONTROL_F, 32'h0);
      rdc(timer16_pkg::OFF_MATCH_FLAGS, 32'hf);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h0);
      wr(timer16_pkg::OFF_COUNT, 32'h1234);
      rdc(timer16_pkg::OFF_COUNT, 32'h1234);
      $display("test compare done");
   endtask : t_cmp

   task automatic t_event;
      int c;
      c = 0;
      // mid-run reset also drops pending ceiling bits left by earlier tests
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      wr(timer16_pkg::OFF_COUNT, 32'h0);
      wr(timer16_pkg::OFF_PERIOD, 32'h2);
      wr(timer16_pkg::OFF_EVENT_CONTROL, 32'h1);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h1);
      for (int i = 0; i < 56; i++) begin
         event_in <= (i < 40) && (i % 4 < 2);
         @(posedge clk);
         if (ceiling_event === 1'b1) c++;
      end
      cmp("event ceilings", 32'h3, c);
      wr(timer16_pkg::OFF_EVENT_CONTROL, 32'h0);
      $display("test event done");
   endtask : t_event

   task automatic t_freq;
      wr(timer16_pkg::OFF_CONTROL_A, 32'h0);
      wr(timer16_pkg::OFF_COUNT, 32'h0);
      wr(timer16_pkg::OFF_COMPARE0, 32'h0);
      wr(timer16_pkg::OFF_CONTROL_B, 32'h11);
      wr(timer16_pkg::OFF_CONTROL_A, 32'h1);
      cmp("oe", 32'h1, {29'h0, wave_output_oe});
      cmp("idle pads", 32'h3, {30'h0, pad[2:1]});
      toggles(24);
      wr(timer16_pkg::OFF_COMPARE0, 32'h2);
      toggles(8);
      wr(timer16_pkg::OFF_CONTROL_B, 32'h0);
      @(posedge clk);
      cmp("oe off", 32'h0, {29'h0, wave_output_oe});
      $display("test frequency done");
   endtask : t_freq

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_up();
      t_shadow();
      t_cmp();
      t_event();
      t_freq();
      end_sim();
   end
endmodule : timer16_buffered_compare_bench

// [tb/wave_pins.sv]
// pin model: port pads whose level the timer may override
`timescale 1ns/1ps
module wave_pins (
   // from the timer
   input wire logic [2:0] wave,
   input wire logic [2:0] oe,
   // port latch level shown while not overridden
   input wire logic [2:0] port_out,
   // pad levels
   output logic [2:0] pad
);
   // pads are set as outputs with no inversion, so the wave shows as is
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pad[i] = oe[i] ? wave[i] : port_out[i];
      end
   end
endmodule : wave_pins
